// file: verilog/fci_host.sv
// fci_host: apb driven controller for a byte wide flash command port
// assumes: apb master on MCLK, memory pins synchronous to MCLK
//
// Overview of operation
// - write strobe low while selected latches
// - release select or output drive between reads
// - erase is 20h then d0h, same block
// - b0h suspends erase, d0h resumes it
// - 40h or 10h, then address and data
// - status bits 2 to 0 masked off
// - clear status after supply low seen
// - check ready before reading error flags
// - write only defined command bytes
`timescale 1ns/10ps
`default_nettype none
`include "fci_map.svh"
module fci_host
    import fci_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RSTN,
    // apb slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // memory bus pins
    output logic [19:0] MEM_ADDR,
    output logic [7:0] MEM_DQ_O,
    output logic MEM_DQ_OE,
    input wire logic [7:0] MEM_DQ_I,
    output logic CHIP_SELECT_N,
    output logic OUTPUT_DRIVE_N,
    output logic WRITE_STROBE_N,
    // powerdown and ready pins
    output logic POWERDOWN_RESET_N,
    input wire logic READY_BUSY_OUT
);
    fci_cyc_if cyc ();

    fci_seq_t st_r;
    logic [3:0] op_r;
    logic [3:0] ctrl_op_r;
    logic [19:0] addr_r;
    logic [7:0] wdata_r;
    logic [19:0] op_addr_r;
    logic [7:0] op_data_r;
    logic pwrdn_r;
    logic done_r;
    logic refused_r;
    logic low_seen_r;
    logic [7:0] rdata_r;
    logic [7:0] status_r;
    logic req_r;
    logic wr_r;
    logic [19:0] req_addr_r;
    logic [7:0] req_data_r;
    logic [7:0] last_cmd_r;
    logic [19:0] last_addr_r;
    logic acc;
    logic wr_acc;
    logic start;
    logic start_ok;
    logic poll_end;

    ////////////////////////////////////////////////////////////////////
    // operation decode
    function automatic logic op_valid(input logic [3:0] op);
        return op <= `FCI_OP_WRITE;
    endfunction : op_valid

    // first command byte of each operation
    function automatic logic [7:0] op_cmd(input logic [3:0] op);
        logic [7:0] cmd;
        cmd = `FCI_CMD_STATUS;
        unique case (op)
            `FCI_OP_ARRAY: cmd = `FCI_CMD_ARRAY;
            `FCI_OP_IDENT: cmd = `FCI_CMD_IDENT;
            `FCI_OP_STATUS: cmd = `FCI_CMD_STATUS;
            `FCI_OP_CLEAR: cmd = `FCI_CMD_CLEAR;
            `FCI_OP_ERASE: cmd = `FCI_CMD_ERASE;
            `FCI_OP_SUSPEND: cmd = `FCI_CMD_SUSPEND;
            `FCI_OP_RESUME: cmd = `FCI_CMD_CONFIRM;
            `FCI_OP_WRITE: cmd = `FCI_CMD_WRITE;
            default: cmd = `FCI_CMD_STATUS;
        endcase
        return cmd;
    endfunction : op_cmd

    // operations that change the array
    function automatic logic op_alters(input logic [3:0] op);
        return op == `FCI_OP_ERASE || op == `FCI_OP_WRITE;
    endfunction : op_alters

    // operations that end in status polling
    function automatic logic op_polls(input logic [3:0] op);
        return op_alters(op) || op == `FCI_OP_SUSPEND ||
               op == `FCI_OP_RESUME;
    endfunction : op_polls

    // operations that end in one read
    function automatic logic op_reads(input logic [3:0] op);
        return op == `FCI_OP_ARRAY || op == `FCI_OP_IDENT ||
               op == `FCI_OP_STATUS;
    endfunction : op_reads

    ////////////////////////////////////////////////////////////////////
    // apb decode
    assign acc = PSEL && PENABLE && PREADY;
    assign wr_acc = acc && PWRITE;
    assign start = wr_acc && PADDR == `FCI_REG_CTRL &&
                   PWDATA[`FCI_CTRL_GO];
    // supply low must be cleared before array changes
    assign start_ok = st_r == S_IDLE && op_valid(PWDATA[3:0]) &&
                      !(op_alters(PWDATA[3:0]) && low_seen_r);

    // one wait state, then answer
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
        end else begin
            PREADY <= PSEL && PENABLE && !PREADY;
            PSLVERR <= 1'b0;
            PRDATA <= 32'h00000000;
            if (PSEL && PENABLE && !PREADY) begin
                unique case (PADDR)
                    `FCI_REG_CTRL: PRDATA <= {23'h000000, pwrdn_r,
                                              4'h0, ctrl_op_r};
                    `FCI_REG_ADDR: PRDATA <= {12'h000, addr_r};
                    `FCI_REG_WDATA: PRDATA <= {24'h000000, wdata_r};
                    `FCI_REG_STAT: PRDATA <= {8'h00, status_r, rdata_r,
                                              3'h0, READY_BUSY_OUT,
                                              low_seen_r, refused_r,
                                              done_r, st_r != S_IDLE};
                    default: PSLVERR <= 1'b1;
                endcase
            end
        end
    end

    // software registers
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_op_r <= `FCI_OP_ARRAY;
            addr_r <= 20'h00000;
            wdata_r <= 8'h00;
            pwrdn_r <= 1'b0;
        end else if (wr_acc) begin
            unique case (PADDR)
                `FCI_REG_CTRL: begin
                    ctrl_op_r <= PWDATA[`FCI_CTRL_OP];
                    pwrdn_r <= PWDATA[`FCI_CTRL_PWRDN];
                end
                `FCI_REG_ADDR: addr_r <= PWDATA[19:0];
                `FCI_REG_WDATA: wdata_r <= PWDATA[7:0];
                default: ;
            endcase
        end
    end

    // powerdown pin, memory returns to array mode on release
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            POWERDOWN_RESET_N <= 1'b1;
        end else begin
            POWERDOWN_RESET_N <= !pwrdn_r;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // operation sequencer and bus cycle requests
    assign poll_end = cyc.done && cyc.rdata[`FCI_SB_READY] &&
                      (op_r != `FCI_OP_SUSPEND ||
                       cyc.rdata[`FCI_SB_SUSP]);

    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            st_r <= S_IDLE;
            op_r <= `FCI_OP_ARRAY;
            op_addr_r <= 20'h00000;
            op_data_r <= 8'h00;
            req_r <= 1'b0;
            wr_r <= 1'b0;
            req_addr_r <= 20'h00000;
            req_data_r <= 8'h00;
        end else begin
            req_r <= 1'b0;
            unique case (st_r)
                S_IDLE: if (start && start_ok) begin
                    op_r <= PWDATA[3:0];
                    op_addr_r <= addr_r;
                    op_data_r <= wdata_r;
                    req_r <= 1'b1;
                    wr_r <= 1'b1;
                    req_addr_r <= addr_r;
                    req_data_r <= op_cmd(PWDATA[3:0]);
                    st_r <= S_CMD1;
                end
                S_CMD1: if (cyc.done) begin
                    req_r <= op_r != `FCI_OP_CLEAR &&
                             op_r != `FCI_OP_ARRAY &&
                             op_r != `FCI_OP_IDENT &&
                             op_r != `FCI_OP_STATUS ||
                             op_reads(op_r);
                    req_addr_r <= op_addr_r;
                    if (op_alters(op_r)) begin
                        // second write goes back to back
                        wr_r <= 1'b1;
                        req_data_r <= op_r == `FCI_OP_ERASE ?
                                      `FCI_CMD_CONFIRM : op_data_r;
                        st_r <= S_CMD2;
                    end else if (op_reads(op_r)) begin
                        wr_r <= 1'b0;
                        st_r <= S_READ;
                    end else if (op_polls(op_r)) begin
                        wr_r <= 1'b0;
                        st_r <= S_POLL;
                    end else begin
                        st_r <= S_IDLE;
                    end
                end
                S_CMD2: if (cyc.done) begin
                    // memory now answers with the status byte
                    req_r <= 1'b1;
                    wr_r <= 1'b0;
                    st_r <= S_POLL;
                end
                S_READ: if (cyc.done) begin
                    st_r <= S_IDLE;
                end
                S_POLL: if (poll_end) begin
                    st_r <= S_IDLE;
                end else if (cyc.done) begin
                    // each poll is a fresh read cycle
                    req_r <= 1'b1;
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    assign cyc.req = req_r;
    assign cyc.wr = wr_r;
    assign cyc.addr = req_addr_r;
    assign cyc.wdata = req_data_r;

    ////////////////////////////////////////////////////////////////////
    // results: read data, status seen once ready, sticky flags
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_r <= 8'h00;
            status_r <= 8'h80;
        end else if (cyc.done && !cyc.wr) begin
            rdata_r <= cyc.rdata;
            if (poll_end && st_r == S_POLL) begin
                status_r <= cyc.rdata & `FCI_SB_MASK;
            end
        end
    end

    // flags: set by hardware wins over clear by a new start
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            done_r <= 1'b0;
            refused_r <= 1'b0;
            low_seen_r <= 1'b0;
        end else begin
            if (start) begin
                done_r <= 1'b0;
                refused_r <= !start_ok;
            end
            if ((st_r == S_POLL && poll_end) ||
                (st_r == S_READ && cyc.done) ||
                (st_r == S_CMD1 && cyc.done && op_r == `FCI_OP_CLEAR)) begin
                done_r <= 1'b1;
            end
            if (st_r == S_CMD1 && cyc.done && op_r == `FCI_OP_CLEAR) begin
                low_seen_r <= 1'b0;
            end
            if (st_r == S_POLL && poll_end && cyc.rdata[`FCI_SB_LOW]) begin
                low_seen_r <= 1'b1;
            end
        end
    end

    // last byte written, command or data, for sequence checks
    always_ff @(posedge MCLK or negedge RSTN) begin
        if (!RSTN) begin
            last_cmd_r <= 8'h00;
            last_addr_r <= 20'h00000;
        end else if (cyc.req && cyc.wr) begin
            last_cmd_r <= cyc.wdata;
            last_addr_r <= cyc.addr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // bus cycle engine
    fci_bus_cycle u_cycle (
        .clk (MCLK),
        .rst_n (RSTN),
        .c (cyc.eng),
        .addr_o (MEM_ADDR),
        .dq_o (MEM_DQ_O),
        .dq_oe (MEM_DQ_OE),
        .dq_i (MEM_DQ_I),
        .cs_n (CHIP_SELECT_N),
        .oe_n (OUTPUT_DRIVE_N),
        .we_n (WRITE_STROBE_N)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN);

    sequence erase_setup_s;
        cyc.req && cyc.wr && cyc.wdata == `FCI_CMD_ERASE;
    endsequence
    sequence next_write_s;
        cyc.req && cyc.wr;
    endsequence

    erase_confirm_a: assert property (
        next_write_s and (last_cmd_r == `FCI_CMD_ERASE) |->
        cyc.wdata == `FCI_CMD_CONFIRM && cyc.addr == last_addr_r)
        else $error("erase setup not followed by confirm");
    erase_pair_a: assert property (
        erase_setup_s |-> ##28 next_write_s)
        else $error("erase confirm missing");
    write_data_a: assert property (
        next_write_s and (last_cmd_r == `FCI_CMD_WRITE) |->
        cyc.wdata == op_data_r && cyc.addr == last_addr_r)
        else $error("write setup not followed by data");
    suspend_end_a: assert property (
        st_r == S_POLL && op_r == `FCI_OP_SUSPEND && cyc.done &&
        cyc.rdata[`FCI_SB_READY] && cyc.rdata[`FCI_SB_SUSP] |=>
        st_r == S_IDLE && done_r)
        else $error("suspend not finished on ready and suspended");
    status_mask_a: assert property (
        status_r[2:0] == 3'h0)
        else $error("reserved status bits not masked");
    supply_gate_a: assert property (
        $rose(st_r != S_IDLE) && op_alters(op_r) |-> !$past(low_seen_r))
        else $error("array change started after supply low");
    ready_first_a: assert property (
        $changed(status_r) |-> status_r[`FCI_SB_READY])
        else $error("error flags taken before ready");
    legal_cmd_a: assert property (
        cyc.req && cyc.wr && st_r == S_CMD1 |->
        cyc.wdata inside {`FCI_CMD_ARRAY, `FCI_CMD_IDENT,
        `FCI_CMD_STATUS, `FCI_CMD_CLEAR, `FCI_CMD_ERASE,
        `FCI_CMD_SUSPEND, `FCI_CMD_CONFIRM, `FCI_CMD_WRITE})
        else $error("undefined command byte written");
    op_start_a: assert property (
        start && start_ok |=> cyc.req ##1 !CHIP_SELECT_N)
        else $error("accepted operation did not start a cycle");
endmodule : fci_host
`default_nettype wire

// file: verilog/fci_map.svh
// fci_map.svh: offsets, fields, codes and timing counts
// assumes: included by its bare name from every file using its macros
`ifndef FCI_MAP_SVH
`define FCI_MAP_SVH

// own register offsets (apb byte addresses)
`define FCI_REG_CTRL 12'h000
`define FCI_REG_ADDR 12'h004
`define FCI_REG_WDATA 12'h008
`define FCI_REG_STAT 12'h00c

// control register fields
`define FCI_CTRL_OP 3:0
`define FCI_CTRL_GO 4
`define FCI_CTRL_PWRDN 8

// operation codes written to the op field
`define FCI_OP_ARRAY 4'h0
`define FCI_OP_IDENT 4'h1
`define FCI_OP_STATUS 4'h2
`define FCI_OP_CLEAR 4'h3
`define FCI_OP_ERASE 4'h4
`define FCI_OP_SUSPEND 4'h5
`define FCI_OP_RESUME 4'h6
`define FCI_OP_WRITE 4'h7

// command bytes of the memory
`define FCI_CMD_ARRAY 8'hff
`define FCI_CMD_IDENT 8'h90
`define FCI_CMD_STATUS 8'h70
`define FCI_CMD_CLEAR 8'h50
`define FCI_CMD_ERASE 8'h20
`define FCI_CMD_CONFIRM 8'hd0
`define FCI_CMD_SUSPEND 8'hb0
`define FCI_CMD_WRITE 8'h40
`define FCI_CMD_WRITE_ALT 8'h10

// status byte fields
`define FCI_SB_READY 7
`define FCI_SB_SUSP 6
`define FCI_SB_ERASE_ERR 5
`define FCI_SB_WRITE_ERR 4
`define FCI_SB_LOW 3
`define FCI_SB_MASK 8'hf8

// bus timing in ns and derived cycle counts (least times, round up)
`define FCI_CLK_NS 4
`define FCI_T_SETUP_NS 10
`define FCI_T_WPULSE_NS 50
`define FCI_T_ACCESS_NS 90
`define FCI_T_HOLD_NS 10
`define FCI_T_GAP_NS 30
`define FCI_CYC(ns) (((ns) + `FCI_CLK_NS - 1) / `FCI_CLK_NS)
`define FCI_SETUP_CYC `FCI_CYC(`FCI_T_SETUP_NS)
`define FCI_WPULSE_CYC `FCI_CYC(`FCI_T_WPULSE_NS)
`define FCI_ACCESS_CYC `FCI_CYC(`FCI_T_ACCESS_NS)
`define FCI_HOLD_CYC `FCI_CYC(`FCI_T_HOLD_NS)
`define FCI_GAP_CYC `FCI_CYC(`FCI_T_GAP_NS)

`endif

// file: verilog/fci_pkg.sv
// fci_pkg: types of the flash command controller
// assumes: fci_map.svh holds the numbers
package fci_pkg;
    typedef enum logic [2:0] {
        S_IDLE, S_CMD1, S_CMD2, S_READ, S_POLL
    } fci_seq_t;
    typedef enum logic [2:0] {
        E_IDLE, E_SETUP, E_STROBE, E_HOLD, E_GAP
    } fci_eng_t;
endpackage : fci_pkg

// file: verilog/fci_cyc_if.sv
// fci_cyc_if: one memory bus cycle request and its answer
// assumes: one clock; req is a one-cycle pulse while engine idle
`timescale 1ns/10ps
`default_nettype none
interface fci_cyc_if;
    logic req;
    logic wr;
    logic [19:0] addr;
    logic [7:0] wdata;
    logic done;
    logic [7:0] rdata;
    modport ctl (output req, wr, addr, wdata, input done, rdata);
    modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface : fci_cyc_if
`default_nettype wire

// file: verilog/fci_bus_cycle.sv
// fci_bus_cycle: runs one read or write cycle on the memory pins
// assumes: memory pins synchronous to clk, dq is split into i/o/oe
`timescale 1ns/10ps
`default_nettype none
`include "fci_map.svh"
module fci_bus_cycle
    import fci_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // request side
    fci_cyc_if.eng c,
    // memory pins
    output logic [19:0] addr_o,
    output logic [7:0] dq_o,
    output logic dq_oe,
    input wire logic [7:0] dq_i,
    output logic cs_n,
    output logic oe_n,
    output logic we_n
);
    fci_eng_t state;
    logic [7:0] cnt;
    logic wr_r;
    logic [7:0] rdata_r;

    ////////////////////////////////////////////////////////////////////
    // pin sequencer: setup, strobe, hold, gap with both strobes high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= E_IDLE;
            cnt <= 8'h00;
            wr_r <= 1'b0;
            addr_o <= 20'h00000;
            dq_o <= 8'h00;
            dq_oe <= 1'b0;
            cs_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            rdata_r <= 8'h00;
        end else begin
            unique case (state)
                E_IDLE: if (c.req) begin
                    wr_r <= c.wr;
                    addr_o <= c.addr;
                    dq_o <= c.wdata;
                    dq_oe <= c.wr;
                    cs_n <= 1'b0;
                    cnt <= 8'(`FCI_SETUP_CYC - 1);
                    state <= E_SETUP;
                end
                E_SETUP: if (cnt == 8'h00) begin
                    we_n <= !wr_r;
                    oe_n <= wr_r;
                    cnt <= wr_r ? 8'(`FCI_WPULSE_CYC - 1)
                                : 8'(`FCI_ACCESS_CYC - 1);
                    state <= E_STROBE;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                E_STROBE: if (cnt == 8'h00) begin
                    // rising write strobe latches addr and data
                    we_n <= 1'b1;
                    oe_n <= 1'b1;
                    if (!wr_r) begin
                        rdata_r <= dq_i;
                    end
                    cnt <= 8'(`FCI_HOLD_CYC - 1);
                    state <= E_HOLD;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                E_HOLD: if (cnt == 8'h00) begin
                    cs_n <= 1'b1;
                    dq_oe <= 1'b0;
                    cnt <= 8'(`FCI_GAP_CYC - 1);
                    state <= E_GAP;
                end else begin
                    cnt <= cnt - 8'h01;
                end
                E_GAP: if (cnt == 8'h00) begin
                    state <= E_IDLE;
                end else begin
                    cnt <= cnt - 8'h01;
                end
            endcase
        end
    end

    // answer to the sequencer
    assign c.done = (state == E_GAP) && (cnt == 8'h00);
    assign c.rdata = rdata_r;

    ////////////////////////////////////////////////////////////////////
    // checks
    strobe_in_select_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        !we_n |-> !cs_n && oe_n && dq_oe)
        else $error("write strobe low outside select");
    read_release_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        $rose(oe_n) |-> ##[1:20] (cs_n && oe_n && c.done))
        else $error("read not released before done");
endmodule : fci_bus_cycle
`default_nettype wire

// file: sim/fci_flash_model.sv
// fci_flash_model: behavioural byte wide flash behind the command port
// assumes: pins change just after MCLK rising edges, dq split in/out
`timescale 1ns/10ps
`default_nettype none
module fci_flash_model #(
    parameter int OP_CYC = 40,
    parameter logic [7:0] MAKER_ID = 8'h5a, // arbitrary value
    parameter logic [7:0] DEVICE_ID = 8'h3e // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // memory pins
    input wire logic [19:0] addr,
    input wire logic [7:0] din,
    input wire logic cs_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic pdn_n,
    output logic [7:0] dout,
    output logic ready_busy,
    // test knobs
    input wire logic supply_high,
    input wire logic op_fail
);
    logic [1:0] mode_r;
    logic [7:0] stat_r, lat_r, setup_r, val, last_r;
    logic we_q, rd_q, er_r;
    int cnt_r;
    ////////////////////////////////////////
    // read data; undriven bus shows the inverse of the last byte
    always_comb begin
        case (mode_r)
            2'd1: val = addr[0] ? DEVICE_ID : MAKER_ID;
            2'd2: val = lat_r;
            default: val = addr[7:0] ^ 8'h3c;
        endcase
    end
    assign dout = (!cs_n && !oe_n) ? val : ~last_r;
    assign ready_busy = stat_r[7];
    // command latch, status flags and operation timer
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n || !pdn_n) begin
            mode_r <= 2'd0;
            stat_r <= 8'h80;
            setup_r <= 8'h00;
            cnt_r <= 0;
            lat_r <= 8'h80;
            last_r <= 8'h00;
            we_q <= 1'b1;
            rd_q <= 1'b0;
            er_r <= 1'b0;
        end else begin
            we_q <= we_n;
            rd_q <= !cs_n && !oe_n;
            if (!cs_n && !oe_n)
                last_r <= val;
            if (!cs_n && !oe_n && !rd_q)
                lat_r <= stat_r;
            if (cnt_r > 0 && !stat_r[6])
                cnt_r <= cnt_r - 1;
            if (cnt_r == 1 && !stat_r[6]) begin
                stat_r[7] <= 1'b1;
                if (op_fail)
                    stat_r[er_r ? 5 : 4] <= 1'b1;
            end
            if (we_n && !we_q && !cs_n) begin
                setup_r <= 8'h00;
                if (setup_r != 8'h00) begin
                    mode_r <= 2'd2;
                    if (setup_r == 8'h20 && din != 8'hd0)
                        stat_r[5:4] <= 2'b11;
                    else if (!supply_high)
                        stat_r[3] <= 1'b1;
                    else begin
                        stat_r[7] <= 1'b0;
                        cnt_r <= OP_CYC;
                        er_r <= setup_r == 8'h20;
                    end
                end else case (din)
                    8'hff: if (stat_r[7]) mode_r <= 2'd0;
                    8'h90: mode_r <= 2'd1;
                    8'h70: mode_r <= 2'd2;
                    8'h50: stat_r[5:3] <= 3'b000;
                    8'hb0: if (!stat_r[7]) stat_r[7:6] <= 2'b11;
                    8'hd0: if (stat_r[6]) stat_r[7:6] <= 2'b00;
                    8'h20, 8'h40, 8'h10: setup_r <= din;
                    default: ;
                endcase
            end
        end
    end
endmodule : fci_flash_model
`default_nettype wire

// file: sim/test_flash_command_interface.sv
// test_flash_command_interface: apb driven checks of fci_host
// assumes: fci_flash_model stands for the memory on the pins
`timescale 1ns/10ps
`default_nettype none
`include "fci_map.svh"
module test_flash_command_interface;
    localparam logic [7:0] MAKER_ID = 8'h5a; // arbitrary value
    localparam logic [7:0] DEVICE_ID = 8'h3e; // arbitrary value
    logic mclk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, supply_high = 1'b1, op_fail = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, st;
    logic pready, pslverr, err, dq_oe, cs_n, oe_n, we_n, pdn_n, rdy;
    logic [19:0] mem_addr, a;
    logic [7:0] dq_o, dq_i, d, exp_sr;
    int fail_count = 0;
    int comparisons = 0;
    ////////////////////////////////////////
    fci_host dut_u (.MCLK(mclk), .RSTN(rstn), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .MEM_ADDR(mem_addr), .MEM_DQ_O(dq_o), .MEM_DQ_OE(dq_oe),
        .MEM_DQ_I(dq_i), .CHIP_SELECT_N(cs_n), .OUTPUT_DRIVE_N(oe_n),
        .WRITE_STROBE_N(we_n), .POWERDOWN_RESET_N(pdn_n),
        .READY_BUSY_OUT(rdy));
    fci_flash_model #(.MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID)) mem_u (
        .clk(mclk), .rst_n(rstn), .addr(mem_addr), .din(dq_o), .cs_n(cs_n),
        .oe_n(oe_n), .we_n(we_n), .pdn_n(pdn_n), .dout(dq_i),
        .ready_busy(rdy), .supply_high(supply_high), .op_fail(op_fail));
    // clock
    initial begin
        forever #2 mclk = ~mclk;
    end
    ////////////////////////////////////////
    task automatic complete_run();
        $display("counts: %0d compared, %0d mismatched", comparisons,
            fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : complete_run
    task automatic chk8(input string what, input logic [7:0] e,
        input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk8
    task automatic chk32(input string what, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask : chk32
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] wd);
        int n;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            fail_count++;
            complete_run();
        end
        st = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // start an operation, poll until idle, check last byte and status
    task automatic run(input logic [3:0] op, input logic [7:0] e);
        int n;
        apb(1'b1, `FCI_REG_ADDR, {12'h0, a});
        apb(1'b1, `FCI_REG_WDATA, {24'h0, d});
        apb(1'b1, `FCI_REG_CTRL, {27'h0, 1'b1, op});
        n = 0;
        do begin
            apb(1'b0, `FCI_REG_STAT, 32'h0);
            n++;
        end while (st[0] !== 1'b0 && n < 500);
        if (n >= 500) begin
            fail_count++;
            complete_run();
        end
        chk8("last byte", e, st[15:8]);
        chk8("ready status", exp_sr & 8'hf8, st[23:16]);
        chk8("done flag", 8'h01, {7'h0, st[1]});
        $display("test op %0d ended", op);
    endtask : run
    ////////////////////////////////////////
    initial begin
        void'($urandom(32'h5c5e));
        exp_sr = 8'h80;
        a = 20'h0;
        d = 8'h0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        apb(1'b0, `FCI_REG_STAT, 32'h0);
        chk32("status word", 32'h0080_0010, st);
        apb(1'b0, 12'h010, 32'h0);
        chk32("unmapped error", {32'h1}, {31'h0, err});
        run(`FCI_OP_IDENT, MAKER_ID);
        a = 20'h00001;
        run(`FCI_OP_IDENT, DEVICE_ID);
        repeat (3) begin
            a = 20'($urandom());
            d = 8'($urandom());
            run(`FCI_OP_ARRAY, a[7:0] ^ 8'h3c);
            run(`FCI_OP_WRITE, 8'h80);
        end
        op_fail <= 1'b1;
        exp_sr = 8'h90;
        run(`FCI_OP_WRITE, 8'h90);
        op_fail <= 1'b0;
        run(`FCI_OP_ERASE, 8'h90);
        op_fail <= 1'b1;
        exp_sr = 8'hb0;
        run(`FCI_OP_ERASE, 8'hb0);
        op_fail <= 1'b0;
        run(`FCI_OP_CLEAR, 8'hb0);
        run(`FCI_OP_STATUS, 8'h80);
        supply_high <= 1'b0;
        exp_sr = 8'h88;
        run(`FCI_OP_ERASE, 8'h88);
        apb(1'b1, `FCI_REG_CTRL, {27'h0, 1'b1, `FCI_OP_WRITE});
        apb(1'b0, `FCI_REG_STAT, 32'h0);
        chk8("refused flag", 8'h01, {7'h0, st[2]});
        run(`FCI_OP_STATUS, 8'h88);
        run(`FCI_OP_CLEAR, 8'h88);
        exp_sr = 8'h80;
        supply_high <= 1'b1;
        run(`FCI_OP_WRITE, 8'h80);
        run(`FCI_OP_RESUME, 8'h80);
        op_fail <= 1'b1;
        exp_sr = 8'h90;
        run(`FCI_OP_WRITE, 8'h90);
        op_fail <= 1'b0;
        apb(1'b1, `FCI_REG_CTRL, 32'h0000_0100);
        apb(1'b1, `FCI_REG_CTRL, 32'h0);
        run(`FCI_OP_STATUS, 8'h80);
        complete_run();
    end
endmodule : test_flash_command_interface
`default_nettype wire
